// [src/dpbr_pkg.sv]
package dpbr_pkg;

  // Array geometry
  localparam int DPBR_ADDR_W = 9;
  localparam int DPBR_DATA_W = 18;
  localparam int DPBR_DEPTH = 512;
  localparam int DPBR_PORTS = 2;

  // APB register map, byte addresses
  localparam int DPBR_PADDR_W = 12;
  localparam logic [11:0] DPBR_CFG_OFS = 12'h000;
  localparam logic [11:0] DPBR_STATUS_OFS = 12'h004;
  localparam logic [11:0] DPBR_RDATA_A_OFS = 12'h008;
  localparam logic [11:0] DPBR_RDATA_B_OFS = 12'h00C;

  // Array operating modes, held in the configuration register
  localparam logic [1:0] DPBR_MODE_TRUE_DUAL = 2'h0;
  localparam logic [1:0] DPBR_MODE_SINGLE = 2'h1;
  localparam logic [1:0] DPBR_MODE_PSEUDO = 2'h2;

  // Configuration register, mode is one 2-bit code; in each other pair bit [p] belongs to port p (0 = A, 1 = B)
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] sync_rst;
    logic [1:0] out_reg;
    logic [1:0] write_thru;
  } dpbr_cfg_type;

  localparam int DPBR_CFG_W = 8;
  localparam logic [7:0] DPBR_CFG_RST = 8'h00;

  // Status register field positions
  localparam int DPBR_ST_CLR_A_BIT = 0;
  localparam int DPBR_ST_CLR_B_BIT = 1;
  localparam int DPBR_ST_GRST_BIT = 2;
  localparam int DPBR_ST_COLL_BIT = 3;
  localparam int DPBR_ST_W = 4;

  // One port request as it enters the input registers
  typedef struct packed {
    logic en;
    logic we;
    logic [DPBR_ADDR_W-1:0] addr;
    logic [DPBR_DATA_W-1:0] data;
  } dpbr_req_type;

  localparam dpbr_req_type DPBR_REQ_RST = '0;
  localparam logic [DPBR_DATA_W-1:0] DPBR_DOUT_RST = 18'h00000;

  typedef enum logic [1:0] {
    DPBR_APB_IDLE = 2'b01,
    DPBR_APB_RESP = 2'b10
  } dpbr_apb_state_type;

endpackage : dpbr_pkg

// [src/dpbr_pin_sync.sv]
`timescale 1ns/10ps
module dpbr_pin_sync
  import dpbr_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_r
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_nxt;

  // Level only moves once the two later stages agree
  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_r <= RST_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

endmodule : dpbr_pin_sync

// [src/dpbr_port_out.sv]
`timescale 1ns/10ps
module dpbr_port_out
  import dpbr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sync_clr,
  input wire dpbr_req_type req,
  input wire logic [DPBR_DATA_W-1:0] mem_rdata,
  input wire logic write_thru,
  input wire logic out_reg_en,
  output logic [DPBR_DATA_W-1:0] rdata_r
);

  logic [DPBR_DATA_W-1:0] latch_r;
  logic [DPBR_DATA_W-1:0] latch_nxt;
  logic [DPBR_DATA_W-1:0] rdata_nxt;

  always_comb begin
    latch_nxt = latch_r;
    if (sync_clr) begin
      latch_nxt = DPBR_DOUT_RST;
    end else if (req.en && req.we && write_thru) begin
      latch_nxt = req.data;
    end else if (req.en && !req.we) begin
      latch_nxt = mem_rdata;
    end
    // A normal write leaves the latch untouched
  end

  // Bypass mode loads the same value as the latch, so the port pin stays a flop
  always_comb begin
    if (sync_clr) begin
      rdata_nxt = DPBR_DOUT_RST;
    end else if (out_reg_en) begin
      rdata_nxt = latch_r;
    end else begin
      rdata_nxt = latch_nxt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= DPBR_DOUT_RST;
      rdata_r <= DPBR_DOUT_RST;
    end else begin
      latch_r <= latch_nxt;
      rdata_r <= rdata_nxt;
    end
  end

endmodule : dpbr_port_out

// [src/dpbr_block_ram.sv]
`timescale 1ns/10ps
module dpbr_block_ram
  import dpbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // Port A, fabric side
  input wire logic port_a_en,
  input wire logic port_a_we,
  input wire logic [DPBR_ADDR_W-1:0] port_a_addr,
  input wire logic [DPBR_DATA_W-1:0] port_a_wdata,
  output logic [DPBR_DATA_W-1:0] port_a_rdata,
  input wire logic port_a_output_reset,
  // Port B, fabric side
  input wire logic port_b_en,
  input wire logic port_b_we,
  input wire logic [DPBR_ADDR_W-1:0] port_b_addr,
  input wire logic [DPBR_DATA_W-1:0] port_b_wdata,
  output logic [DPBR_DATA_W-1:0] port_b_rdata,
  input wire logic port_b_output_reset,
  // Device-wide output clear
  input wire logic global_reset_n,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DPBR_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Port requests and array
  dpbr_req_type req_in [DPBR_PORTS];
  dpbr_req_type req_nxt [DPBR_PORTS];
  dpbr_req_type req_r [DPBR_PORTS];
  logic [DPBR_DATA_W-1:0] mem [DPBR_DEPTH];
  logic [DPBR_DATA_W-1:0] mem_rd [DPBR_PORTS];
  logic [DPBR_DATA_W-1:0] dout [DPBR_PORTS];
  logic [DPBR_PORTS-1:0] wr_en;
  logic [DPBR_PORTS-1:0] local_rst;
  logic [DPBR_PORTS-1:0] clr_lvl;
  logic [DPBR_PORTS-1:0] sync_clr;
  logic [DPBR_PORTS-1:0] port_arst_n;
  logic [DPBR_PORTS-1:0] async_clr;
  logic [DPBR_PORTS-1:0] wt_eff;
  logic grst_n_lvl;
  logic same_addr;
  logic coll_set;

  // Software-visible state
  dpbr_cfg_type cfg_r;
  dpbr_cfg_type cfg_nxt;
  logic coll_r;
  logic coll_nxt;

  // Register bus slave
  dpbr_apb_state_type apb_state_r;
  dpbr_apb_state_type apb_state_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [DPBR_ST_W-1:0] status;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic apb_commit;
  logic apb_take;
  logic cfg_wr;
  logic coll_clr;

  // Global reset pin comes from outside this clock domain
  dpbr_pin_sync #(
    .RST_VAL(1'b1)
  ) u_grst_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(global_reset_n),
    .level_r(grst_n_lvl)
  );

  // Input registers; the operating mode masks what each port may do
  always_comb begin
    req_in[0].en = port_a_en;
    req_in[0].we = port_a_we;
    req_in[0].addr = port_a_addr;
    req_in[0].data = port_a_wdata;
    req_in[1].en = port_b_en;
    req_in[1].we = port_b_we;
    req_in[1].addr = port_b_addr;
    req_in[1].data = port_b_wdata;
    req_nxt = req_in;
    case (cfg_r.mode)
      DPBR_MODE_SINGLE: begin
        // Port B is unused in single port operation
        req_nxt[1].en = 1'b0;
      end
      DPBR_MODE_PSEUDO: begin
        // Port A writes only, port B reads only
        req_nxt[0].en = port_a_en & port_a_we;
        req_nxt[1].we = 1'b0;
      end
      default: begin
        req_nxt = req_in;
      end
    endcase
  end

  // Registered on every edge, with the mode mask already applied
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r[0] <= DPBR_REQ_RST;
      req_r[1] <= DPBR_REQ_RST;
    end else begin
      req_r <= req_nxt;
    end
  end

  // Array: reads see the old word when a write lands on the same edge
  always_comb begin
    for (int p = 0; p < DPBR_PORTS; p++) begin
      wr_en[p] = req_r[p].en & req_r[p].we;
      mem_rd[p] = mem[req_r[p].addr];
    end
    same_addr = (req_r[0].addr == req_r[1].addr);
    coll_set = wr_en[0] & wr_en[1] & same_addr;
  end

  // Port A is written last so it wins a same-address collision
  always_ff @(posedge clk) begin
    if (wr_en[1]) begin
      mem[req_r[1].addr] <= req_r[1].data;
    end
    if (wr_en[0]) begin
      mem[req_r[0].addr] <= req_r[0].data;
    end
  end

  // Output clear sources per port
  // Global clear reaches both ports only through its synchroniser
  always_comb begin
    local_rst[0] = port_a_output_reset;
    local_rst[1] = port_b_output_reset;
    for (int p = 0; p < DPBR_PORTS; p++) begin
      clr_lvl[p] = local_rst[p] | ~grst_n_lvl;
      sync_clr[p] = cfg_r.sync_rst[p] & clr_lvl[p];
      // Gated asynchronous clear; local clears must come from fabric flops to stay glitch free
      async_clr[p] = ~cfg_r.sync_rst[p] & clr_lvl[p];
      port_arst_n[p] = rst_n & ~async_clr[p];
      // Write-through only has meaning where a port both reads and writes
      wt_eff[p] = cfg_r.write_thru[p] & (cfg_r.mode != DPBR_MODE_PSEUDO);
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < DPBR_PORTS; gp++) begin : g_port
      // Each port has its own latch, so one clear leaves the other alone
      dpbr_port_out u_out (
        .clk(clk),
        .arst_n(port_arst_n[gp]),
        .sync_clr(sync_clr[gp]),
        .req(req_r[gp]),
        .mem_rdata(mem_rd[gp]),
        .write_thru(wt_eff[gp]),
        .out_reg_en(cfg_r.out_reg[gp]),
        .rdata_r(dout[gp])
      );
    end
  endgenerate

  // Port outputs come straight from the output stage flops
  assign port_a_rdata = dout[0];
  assign port_b_rdata = dout[1];

  // APB slave: one wait state, then pready for a single cycle
  always_comb begin
    status = '0;
    status[DPBR_ST_CLR_A_BIT] = clr_lvl[0];
    status[DPBR_ST_CLR_B_BIT] = clr_lvl[1];
    status[DPBR_ST_GRST_BIT] = ~grst_n_lvl;
    status[DPBR_ST_COLL_BIT] = coll_r;
  end

  // Unmapped offsets read zero and raise pslverr
  always_comb begin
    addr_hit = 1'b1;
    case (paddr)
      DPBR_CFG_OFS: begin
        rd_mux = 32'(cfg_r);
      end
      DPBR_STATUS_OFS: begin
        rd_mux = 32'(status);
      end
      DPBR_RDATA_A_OFS: begin
        rd_mux = 32'(dout[0]);
      end
      DPBR_RDATA_B_OFS: begin
        rd_mux = 32'(dout[1]);
      end
      default: begin
        rd_mux = 32'h00000000;
        addr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    apb_state_nxt = apb_state_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h00000000;
    apb_commit = 1'b0;
    apb_take = psel & penable;
    case (apb_state_r)
      DPBR_APB_IDLE: begin
        if (apb_take) begin
          apb_state_nxt = DPBR_APB_RESP;
          pready_nxt = 1'b1;
          pslverr_nxt = ~addr_hit;
          if (pwrite) begin
            prdata_nxt = 32'h00000000;
          end else begin
            prdata_nxt = rd_mux;
          end
        end
      end
      DPBR_APB_RESP: begin
        // Master still holds address and data while pready is seen
        apb_state_nxt = DPBR_APB_IDLE;
        apb_commit = apb_take & pwrite;
      end
      default: begin
        // Illegal state code falls back to idle
        apb_state_nxt = DPBR_APB_IDLE;
      end
    endcase
  end

  // Response flops; prdata reads zero outside the pready cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      apb_state_r <= DPBR_APB_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      apb_state_r <= apb_state_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Configuration and sticky collision flag; a new collision beats its clear
  always_comb begin
    cfg_wr = apb_commit && (paddr == DPBR_CFG_OFS);
    // Write one to clear, so other status bits are never disturbed by software
    coll_clr = apb_commit && (paddr == DPBR_STATUS_OFS) && pwdata[DPBR_ST_COLL_BIT];
    cfg_nxt = cfg_r;
    coll_nxt = coll_r;
    if (cfg_wr) begin
      cfg_nxt = pwdata[DPBR_CFG_W-1:0];
    end
    if (coll_clr) begin
      coll_nxt = 1'b0;
    end
    if (coll_set) begin
      coll_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= DPBR_CFG_RST;
      coll_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      coll_r <= coll_nxt;
    end
  end

endmodule : dpbr_block_ram

// [bench/dpbr_block_ram_chk.sv]
`timescale 1ns/10ps
module dpbr_block_ram_chk
  import dpbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port_a_en,
  input wire logic port_a_we,
  input wire logic [DPBR_DATA_W-1:0] port_a_wdata,
  input wire logic [DPBR_DATA_W-1:0] port_a_rdata,
  input wire logic port_a_output_reset,
  input wire logic port_b_en,
  input wire logic port_b_we,
  input wire logic [DPBR_DATA_W-1:0] port_b_rdata,
  input wire logic port_b_output_reset,
  input wire logic global_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DPBR_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready
);
  dpbr_cfg_type cfg_r;
  logic [2:0] gcnt_r;
  logic g_ok, psd, rd_a, rd_b, nrm_a, nrm_b, wt_a;
  assign psd = cfg_r.mode == DPBR_MODE_PSEUDO;
  // Global clear passes a synchroniser, so trust outputs only after it settled
  assign g_ok = gcnt_r >= 3'h5;
  assign rd_a = port_a_en && !port_a_we;
  assign rd_b = port_b_en && (!port_b_we || psd);
  assign nrm_a = !cfg_r.write_thru[0] || psd;
  assign nrm_b = !cfg_r.write_thru[1] || psd;
  assign wt_a = !nrm_a && port_a_en && port_a_we && !port_a_output_reset && g_ok;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= DPBR_CFG_RST;
      gcnt_r <= 3'h0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == DPBR_CFG_OFS) cfg_r <= pwdata[7:0];
      gcnt_r <= !global_reset_n ? 3'h0 : (g_ok ? gcnt_r : gcnt_r + 3'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wt_a;
    (wt_a && !cfg_r.out_reg[0]) ##1 !port_a_output_reset |=>
      (port_a_output_reset || port_a_rdata == $past(port_a_wdata, 2));
  endproperty
  a_wt_a: assert property (p_wt_a) else $error("write-through A");
  property p_wt_reg;
    (wt_a && cfg_r.out_reg[0]) ##1 !port_a_output_reset [*2] |=>
      (port_a_output_reset || port_a_rdata == $past(port_a_wdata, 3));
  endproperty
  a_wt_reg: assert property (p_wt_reg) else $error("registered write-through A");
  property p_norm_a;
    (g_ok && nrm_a && !port_a_output_reset && !$past(rd_a) && !$past(rd_a, 2)) |=>
      (port_a_output_reset || $stable(port_a_rdata));
  endproperty
  a_norm_a: assert property (p_norm_a) else $error("A output moved without read");
  property p_norm_b;
    (g_ok && nrm_b && !port_b_output_reset && !$past(rd_b) && !$past(rd_b, 2)) |=>
      (port_b_output_reset || $stable(port_b_rdata));
  endproperty
  a_norm_b: assert property (p_norm_b) else $error("B output moved without read");
  property p_clr_a;
    port_a_output_reset [*2] |-> port_a_rdata == DPBR_DOUT_RST;
  endproperty
  a_clr_a: assert property (p_clr_a) else $error("A clear");
  property p_clr_b;
    port_b_output_reset [*2] |-> port_b_rdata == DPBR_DOUT_RST;
  endproperty
  a_clr_b: assert property (p_clr_b) else $error("B clear");
  property p_only_a;
    (port_a_output_reset && g_ok && !port_b_output_reset && !$past(port_b_en) && !$past(port_b_en, 2)) |=>
      (port_b_output_reset || $stable(port_b_rdata));
  endproperty
  a_only_a: assert property (p_only_a) else $error("A clear touched B");
  property p_gclr;
    !global_reset_n [*7] |-> (port_a_rdata == DPBR_DOUT_RST && port_b_rdata == DPBR_DOUT_RST);
  endproperty
  a_gclr: assert property (p_gclr) else $error("global clear");
endmodule : dpbr_block_ram_chk
bind dpbr_block_ram dpbr_block_ram_chk u_chk (.clk, .rst_n, .port_a_en, .port_a_we, .port_a_wdata,
  .port_a_rdata, .port_a_output_reset, .port_b_en, .port_b_we, .port_b_rdata, .port_b_output_reset,
  .global_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);

// [bench/dpbr_fabric_model.sv]
`timescale 1ns/10ps
module dpbr_fabric_model
  import dpbr_pkg::*;
(
  input wire logic clk,
  output dpbr_req_type req_a,
  output dpbr_req_type req_b
);
  initial begin
    req_a = DPBR_REQ_RST;
    req_b = DPBR_REQ_RST;
  end
  // Released lines show the inverse, so a stale value never looks valid
  function automatic dpbr_req_type off(input dpbr_req_type r);
    return dpbr_req_type'{1'b0, ~r.we, ~r.addr, ~r.data};
  endfunction : off
  task automatic op(input logic p, input logic w, input logic [8:0] a, input logic [17:0] d);
    @(posedge clk);
    req_a <= p ? off(req_a) : dpbr_req_type'{1'b1, w, a, d};
    req_b <= p ? dpbr_req_type'{1'b1, w, a, d} : off(req_b);
  endtask : op
  task automatic op2(input logic [8:0] a, input logic [17:0] da, input logic [17:0] db);
    @(posedge clk);
    req_a <= dpbr_req_type'{1'b1, 1'b1, a, da};
    req_b <= dpbr_req_type'{1'b1, 1'b1, a, db};
  endtask : op2
  task automatic idle();
    @(posedge clk);
    req_a <= off(req_a);
    req_b <= off(req_b);
  endtask : idle
endmodule : dpbr_fabric_model

// [bench/dpbr_block_ram_tb.sv]
`timescale 1ns/10ps
module dpbr_block_ram_tb
  import dpbr_pkg::*;
;
  logic clk, rst_n, clr_a, clr_b, grst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [17:0] rdata_a, rdata_b;
  dpbr_req_type req_a, req_b;
  int fail_count, num_checks, cyc;
  dpbr_fabric_model u_fab (.clk(clk), .req_a(req_a), .req_b(req_b));
  dpbr_block_ram u_dut (.clk(clk), .rst_n(rst_n), .port_a_en(req_a.en), .port_a_we(req_a.we),
    .port_a_addr(req_a.addr), .port_a_wdata(req_a.data), .port_a_rdata(rdata_a), .port_a_output_reset(clr_a),
    .port_b_en(req_b.en), .port_b_we(req_b.we), .port_b_addr(req_b.addr), .port_b_wdata(req_b.data),
    .port_b_rdata(rdata_b), .port_b_output_reset(clr_b), .global_reset_n(grst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic acc(input logic p, input logic w, input logic [8:0] a, input logic [17:0] d, input int lat);
    u_fab.op(p, w, a, d);
    u_fab.idle();
    repeat (lat) @(posedge clk);
    #1 v = {14'h0, p ? rdata_b : rdata_a};
  endtask : acc
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {rst_n, clr_a, clr_b, psel, penable, pwrite, paddr, pwdata} = '0;
    grst_n = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, DPBR_CFG_OFS, 32'h0);
    chk("cfg", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    acc(1'b0, 1'b1, 9'h005, 18'h2ABCD, 1);
    acc(1'b0, 1'b0, 9'h005, 18'h0, 1);
    chk("a_read", 32'h2ABCD, v);
    apb(1'b0, DPBR_RDATA_A_OFS, 32'h0);
    chk("apb_rdata_a", 32'h2ABCD, rd);
    acc(1'b0, 1'b1, 9'h005, 18'h11111, 1);
    chk("a_norm_wr", 32'h2ABCD, v);
    acc(1'b1, 1'b0, 9'h005, 18'h0, 1);
    chk("b_read", 32'h11111, v);
    for (int o = 0; o < 2; o++) begin
      apb(1'b1, DPBR_CFG_OFS, o ? 32'h0000000F : 32'h00000003);
      acc(1'b0, 1'b1, 9'h0A0, {17'h1E1E1, o[0]}, 1);
      chk("a_wt_early", 32'h3C3C2, v);
      @(posedge clk);
      #1 chk("a_wt", {14'h0, 17'h1E1E1, o[0]}, {14'h0, rdata_a});
      acc(1'b1, 1'b1, 9'h0A1, 18'h05A5A, 2);
      chk("b_wt", 32'h05A5A, v);
    end
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, DPBR_CFG_OFS, s ? 32'h00000030 : 32'h00000000);
      acc(1'b0, 1'b0, 9'h005, 18'h0, 1);
      acc(1'b1, 1'b0, 9'h0A1, 18'h0, 1);
      @(posedge clk);
      clr_a <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("a_clr", 32'h0, {14'h0, rdata_a});
      chk("b_kept", 32'h05A5A, {14'h0, rdata_b});
      apb(1'b0, DPBR_STATUS_OFS, 32'h0);
      chk("st_clr_a", 32'h1, rd);
      @(posedge clk);
      clr_a <= 1'b0;
      clr_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("b_clr", 32'h0, {14'h0, rdata_b});
      @(posedge clk);
      clr_b <= 1'b0;
    end
    u_fab.op2(9'h0C0, 18'h0AAAA, 18'h05555);
    u_fab.idle();
    apb(1'b0, DPBR_STATUS_OFS, 32'h0);
    chk("st_coll", 32'h8, rd);
    acc(1'b0, 1'b0, 9'h0C0, 18'h0, 1);
    chk("coll_a_wins", 32'h0AAAA, v);
    apb(1'b1, DPBR_STATUS_OFS, 32'h8);
    apb(1'b0, DPBR_STATUS_OFS, 32'h0);
    chk("st_coll_clr", 32'h0, rd);
    acc(1'b1, 1'b0, 9'h005, 18'h0, 1);
    chk("b_read2", 32'h11111, v);
    apb(1'b1, DPBR_CFG_OFS, 32'h00000040);
    acc(1'b1, 1'b0, 9'h0A0, 18'h0, 1);
    chk("single_b_off", 32'h11111, v);
    acc(1'b0, 1'b0, 9'h0A0, 18'h0, 1);
    chk("single_a_read", 32'h3C3C3, v);
    apb(1'b1, DPBR_CFG_OFS, 32'h00000080);
    acc(1'b0, 1'b0, 9'h0C0, 18'h0, 1);
    chk("pseudo_a_rd_off", 32'h3C3C3, v);
    acc(1'b1, 1'b1, 9'h0A0, 18'h3FFFF, 1);
    chk("pseudo_b_rd", 32'h3C3C3, v);
    acc(1'b0, 1'b1, 9'h007, 18'h15555, 1);
    acc(1'b1, 1'b0, 9'h007, 18'h0, 1);
    chk("pseudo_a_wr", 32'h15555, v);
    apb(1'b1, DPBR_CFG_OFS, 32'h00000030);
    acc(1'b0, 1'b0, 9'h005, 18'h0, 1);
    acc(1'b1, 1'b0, 9'h0A1, 18'h0, 1);
    @(posedge clk);
    grst_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("g_clr", 32'h0, {14'h0, rdata_a | rdata_b});
    apb(1'b0, DPBR_STATUS_OFS, 32'h0);
    chk("st_grst", 32'h7, rd);
    @(posedge clk);
    grst_n <= 1'b1;
    stop_test();
  end
endmodule : dpbr_block_ram_tb
